// File: rtl/gdfm_pkg.sv
// Operation
// - Supply undervoltage reports, floats gates, stops logic; recovers automatically.
// - Pump undervoltage, when enabled, reports and floats gates; recovers automatically.
// - Pump undervoltage with its disable bit set does nothing.
// - Overcurrent mode 00b reports and floats gates until a fault clear.
// - Overcurrent mode 01b reports and floats gates, resuming after retry time.
// - Overcurrent mode 10b only reports; gates keep driving.
// - Overcurrent mode 11b neither reports nor acts.
// - Sense overcurrent disable silences the sense-resistor overcurrent alone, any mode.
// - Enabled stuck-gate fault reports and floats gates until a fault clear.
// - Stuck-gate fault with its disable bit set does nothing.
// - Thermal warning with report bit set reports only, clearing automatically.
// - Thermal warning with report bit clear does nothing.
// - Thermal shutdown reports and floats gates; recovers automatically.
// - Each fault latches general and specific status bits until a fault clear, or for retry overcurrent until the retry ends.
// - Hardware variant fixes overcurrent to retry, 4 ms period, 4 us deglitch.
package gdfm_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_NS        = 25;
  localparam int OCP_DEG_NS    = 4000;
  localparam int RETRY_US      = 4000;
  localparam int DEG_CYC       = (OCP_DEG_NS + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_CYC_DEF = (RETRY_US * 1000) / CLK_NS;
  localparam int DCW           = $clog2(DEG_CYC + 1);

  // ==========================================================================
  // Condition indices
  localparam int NCOND   = 7;
  localparam int C_SUV   = 0;
  localparam int C_PUV   = 1;
  localparam int C_DSOC  = 2;
  localparam int C_SNOC  = 3;
  localparam int C_GSF   = 4;
  localparam int C_TWN   = 5;
  localparam int C_TSD   = 6;
  localparam int R_EN    = 7;
  localparam int R_STRAP = 8;
  localparam int R_PIN   = 9;
  localparam int RAW_W   = 10;

  // ==========================================================================
  // Register map
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_FSTAT = 8'h04;
  localparam logic [7:0] A_LIVE  = 8'h08;
  localparam logic [7:0] A_ISTAT = 8'h0c;
  localparam logic [7:0] A_IMASK = 8'h10;

  localparam int F_OCM  = 0;
  localparam int F_PUVD = 2;
  localparam int F_SOCD = 3;
  localparam int F_GFD  = 4;
  localparam int F_TWR  = 5;
  localparam int F_CLR  = 6;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h00;
  localparam logic [NCOND:0]    FSTAT_RST = 8'h00;
  localparam logic [NCOND-1:0]  IRQ_RST   = 7'h00;

  localparam logic [1:0] OCM_LATCH  = 2'h0;
  localparam logic [1:0] OCM_RETRY  = 2'h1;
  localparam logic [1:0] OCM_REPORT = 2'h2;
  localparam logic [1:0] OCM_OFF    = 2'h3;

  typedef enum logic [1:0] {
    OC_IDLE,
    OC_LATCHED,
    OC_RETRY,
    OC_REPORT
  } gdfm_oc_state_t;

endpackage

// File: rtl/gdfm_cond_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gdfm_cond_if;
  import gdfm_pkg::*;
  logic [NCOND-1:0] cond;
  logic             en_pulse;
  logic             strap;
  logic             pin_lvl;
  modport src (output cond, output en_pulse, output strap, output pin_lvl);
  modport dst (input cond, input en_pulse, input strap, input pin_lvl);
endinterface
`default_nettype wire

// File: rtl/gdfm_cond.sv
`timescale 1ns/1ps
`default_nettype none
module gdfm_cond (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic [gdfm_pkg::RAW_W-1:0] raw,
  gdfm_cond_if.src                      co
);
  import gdfm_pkg::*;

  // ==========================================================================
  // Two-stage synchroniser; only the second stage feeds logic.
  logic [RAW_W-1:0] s1_r;
  logic [RAW_W-1:0] s2_r;
  logic             en_d_r;
  logic [DCW-1:0]   dg_r [2];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= s2_r[R_EN];
    end
  end

  // ==========================================================================
  // Overcurrent deglitch: a comparator must stay high for the full window.
  // A single low sample restarts the window, so chatter never accumulates.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dg_r[0] <= '0;
      dg_r[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!s2_r[C_DSOC+i]) begin
          dg_r[i] <= '0;
        end else if (dg_r[i] != DCW'(DEG_CYC)) begin
          dg_r[i] <= dg_r[i] + DCW'(1);
        end
      end
    end
  end

  always_comb begin
    co.cond         = s2_r[NCOND-1:0];
    co.cond[C_DSOC] = (dg_r[0] == DCW'(DEG_CYC));
    co.cond[C_SNOC] = (dg_r[1] == DCW'(DEG_CYC));
  end

  assign co.en_pulse = s2_r[R_EN] & ~en_d_r;
  assign co.strap    = s2_r[R_STRAP];
  assign co.pin_lvl  = s2_r[R_PIN];

endmodule
`default_nettype wire

// File: rtl/gdfm_top.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gdfm_top #(
  parameter int RETRY_CYC = gdfm_pkg::RETRY_CYC_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        supply_undervoltage,
  input  wire logic        pump_undervoltage,
  input  wire logic        drain_source_overcurrent,
  input  wire logic        sense_resistor_overcurrent,
  input  wire logic        gate_stuck_fault,
  input  wire logic        thermal_warning,
  input  wire logic        thermal_shutdown,
  input  wire logic        enable_reset_pulse,
  input  wire logic        hw_iface_strap,
  input  wire logic        fault_report_n_i,
  output logic             fault_report_n_o,
  output logic             fault_report_n_oe,
  output logic             gate_hiz,
  output logic             logic_disable,
  output logic             irq
);
  import gdfm_pkg::*;

  localparam int RCW = $clog2(RETRY_CYC);
  localparam logic [RCW-1:0] RLAST = RCW'(RETRY_CYC - 1);

  // ==========================================================================
  // Input conditioning
  gdfm_cond_if cif ();

  gdfm_cond u_cond (
    .mclk  (mclk),
    .rst_b (rst_b),
    .raw   ({fault_report_n_i,
             hw_iface_strap,
             enable_reset_pulse,
             thermal_shutdown,
             thermal_warning,
             gate_stuck_fault,
             sense_resistor_overcurrent,
             drain_source_overcurrent,
             pump_undervoltage,
             supply_undervoltage}),
    .co    (cif.src)
  );

  logic [NCOND-1:0] cnd;
  logic             hw;

  assign cnd = cif.cond;
  assign hw  = cif.strap;

  // ==========================================================================
  // Configuration
  logic [CTRL_W-1:0] ctrl_r;
  logic [1:0]        ocm;
  logic              puv_en;
  logic              socd;
  logic              gf_en;
  logic              twr;
  logic              clr_cmd;
  logic              flt_clr;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
    end else if (wr && addr == A_CTRL) begin
      ctrl_r <= wdata[CTRL_W-1:0];
    end
  end

  // The hardware variant has no configuration bits, so the strap overrides all of them except
  // the thermal warning report bit; software writes still land but have no effect on the overridden bits.
  assign ocm    = hw ? OCM_RETRY : ctrl_r[F_OCM +: 2];
  assign puv_en = hw | ~ctrl_r[F_PUVD];
  assign socd   = ~hw & ctrl_r[F_SOCD];
  assign gf_en  = hw | ~ctrl_r[F_GFD];
  assign twr    = ctrl_r[F_TWR];

  // Clear is a self-clearing command bit; it always reads as zero.
  assign clr_cmd = wr && addr == A_CTRL && wdata[F_CLR];
  assign flt_clr = clr_cmd | cif.en_pulse;

  // ==========================================================================
  // Per-fault qualification
  logic             ds_ev;
  logic             sn_ev;
  logic             oc_ev;
  logic [NCOND-1:0] rep;

  assign ds_ev = cnd[C_DSOC];
  assign sn_ev = cnd[C_SNOC] & ~socd;
  assign oc_ev = (ds_ev | sn_ev) & (ocm != OCM_OFF);

  always_comb begin
    rep         = '0;
    rep[C_SUV]  = cnd[C_SUV];
    rep[C_PUV]  = cnd[C_PUV] & puv_en;
    rep[C_DSOC] = ds_ev & (ocm != OCM_OFF);
    rep[C_SNOC] = sn_ev & (ocm != OCM_OFF);
    rep[C_GSF]  = cnd[C_GSF] & gf_en;
    rep[C_TWN]  = cnd[C_TWN] & twr;
    rep[C_TSD]  = cnd[C_TSD];
  end

  // ==========================================================================
  // Overcurrent response
  gdfm_oc_state_t oc_st_r;
  gdfm_oc_state_t oc_st_nxt;
  logic [RCW-1:0] rcnt_r;
  logic           retry_done;

  assign retry_done = (oc_st_r == OC_RETRY) && (rcnt_r == RLAST);

  // Latched and report-only states leave only once the condition is gone,
  // so a clear issued into a live overcurrent does not release the gates.
  always_comb begin
    oc_st_nxt = oc_st_r;
    unique case (oc_st_r)
      OC_IDLE: begin
        if (oc_ev) begin
          unique case (ocm)
            OCM_LATCH:  oc_st_nxt = OC_LATCHED;
            OCM_RETRY:  oc_st_nxt = OC_RETRY;
            OCM_REPORT: oc_st_nxt = OC_REPORT;
            OCM_OFF:    oc_st_nxt = OC_IDLE;
          endcase
        end
      end
      OC_LATCHED: begin
        if (flt_clr && !(ds_ev | sn_ev)) begin
          oc_st_nxt = OC_IDLE;
        end
      end
      OC_RETRY: begin
        if (retry_done) begin
          oc_st_nxt = OC_IDLE;
        end
      end
      OC_REPORT: begin
        if (flt_clr && !(ds_ev | sn_ev)) begin
          oc_st_nxt = OC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      oc_st_r <= OC_IDLE;
    end else begin
      oc_st_r <= oc_st_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rcnt_r <= '0;
    end else if (oc_st_r == OC_RETRY && !retry_done) begin
      rcnt_r <= rcnt_r + RCW'(1);
    end else begin
      rcnt_r <= '0;
    end
  end

  // ==========================================================================
  // Gate drive fault latch
  logic gdf_lat_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gdf_lat_r <= 1'b0;
    end else if (rep[C_GSF]) begin
      gdf_lat_r <= 1'b1;
    end else if (flt_clr) begin
      gdf_lat_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Fault pin and gate disable
  logic fault_any;
  logic hiz_any;

  assign fault_any = rep[C_SUV] | rep[C_PUV] | (oc_st_r != OC_IDLE)
                   | gdf_lat_r | rep[C_TWN] | rep[C_TSD];
  assign hiz_any = rep[C_SUV] | rep[C_PUV] | (oc_st_r == OC_LATCHED)
                 | (oc_st_r == OC_RETRY) | gdf_lat_r | rep[C_TSD];

  // The pin is open drain: it is only ever pulled low, never driven high.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fault_report_n_o  <= 1'b0;
      fault_report_n_oe <= 1'b0;
      gate_hiz          <= 1'b0;
      logic_disable     <= 1'b0;
    end else begin
      fault_report_n_o  <= 1'b0;
      fault_report_n_oe <= fault_any;
      gate_hiz          <= hiz_any;
      logic_disable     <= rep[C_SUV];
    end
  end

  // ==========================================================================
  // Fault status
  logic [NCOND:0] fstat_r;
  logic [NCOND:0] fstat_nxt;

  // New evidence beats a clear in the same cycle.
  always_comb begin
    fstat_nxt = fstat_r;
    if (flt_clr) begin
      fstat_nxt = '0;
    end
    if (retry_done) begin
      fstat_nxt[1+C_DSOC] = 1'b0;
      fstat_nxt[1+C_SNOC] = 1'b0;
    end
    fstat_nxt[NCOND:1] = fstat_nxt[NCOND:1] | rep;
    fstat_nxt[0]       = |fstat_nxt[NCOND:1];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fstat_r <= FSTAT_RST;
    end else begin
      fstat_r <= fstat_nxt;
    end
  end

  // ==========================================================================
  // Interrupts
  logic [NCOND-1:0] istat_r;
  logic [NCOND-1:0] imask_r;
  logic [NCOND-1:0] irq_ev;
  logic [NCOND-1:0] w1c;

  assign irq_ev = rep & ~fstat_r[NCOND:1];
  assign w1c    = (wr && addr == A_ISTAT) ? wdata[NCOND-1:0] : '0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      istat_r <= IRQ_RST;
    end else begin
      istat_r <= (istat_r & ~w1c) | irq_ev;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      imask_r <= IRQ_RST;
    end else if (wr && addr == A_IMASK) begin
      imask_r <= wdata[NCOND-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_r & imask_r);
    end
  end

  // ==========================================================================
  // Register read
  logic [31:0] rd_val;

  always_comb begin
    rd_val = '0;
    unique case (addr)
      A_CTRL:  rd_val[CTRL_W-1:0] = ctrl_r;
      A_FSTAT: rd_val[NCOND:0]    = fstat_r;
      A_LIVE:  rd_val[11:0]       = {oc_st_r == OC_RETRY, hw,
                                     logic_disable, gate_hiz,
                                     cif.pin_lvl, cnd};
      A_ISTAT: rd_val[NCOND-1:0]  = istat_r;
      A_IMASK: rd_val[NCOND-1:0]  = imask_r;
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rd_val : '0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  uv_lock_a: assert property (
    cnd[C_SUV] |=> gate_hiz && logic_disable && fault_report_n_oe)
    else $error("undervoltage did not lock the drivers");

  puv_on_a: assert property (
    cnd[C_PUV] && puv_en |=> gate_hiz && fault_report_n_oe)
    else $error("pump undervoltage not acted on");

  puv_off_a: assert property (
    cnd == (NCOND'(1) << C_PUV) && !puv_en && oc_st_r == OC_IDLE && !gdf_lat_r
    |=> !gate_hiz && !fault_report_n_oe)
    else $error("disabled pump undervoltage acted");

  oc_hold_a: assert property (
    oc_st_r == OC_LATCHED && !flt_clr |=> oc_st_r == OC_LATCHED ##1 gate_hiz)
    else $error("latched overcurrent released without clear");

  retry_len_a: assert property (
    $rose(oc_st_r == OC_RETRY) |-> rcnt_r == '0 ##1 gate_hiz)
    else $error("retry did not start from zero with gates off");

  retry_end_a: assert property (
    oc_st_r == OC_RETRY && rcnt_r == RLAST |=> oc_st_r == OC_IDLE)
    else $error("retry period wrong length");

  hw_retry_a: assert property (
    hw && oc_st_r == OC_IDLE && oc_ev |=> oc_st_r == OC_RETRY)
    else $error("hardware variant did not retry");

  rep_only_a: assert property (
    oc_st_r == OC_REPORT |=> fault_report_n_oe)
    else $error("report-only overcurrent not reported");

  oc_off_a: assert property (
    oc_st_r == OC_IDLE && ocm == OCM_OFF |=> oc_st_r == OC_IDLE)
    else $error("disabled overcurrent acted");

  sen_dis_a: assert property (
    socd && !ds_ev && oc_st_r == OC_IDLE |=> oc_st_r == OC_IDLE)
    else $error("disabled sense overcurrent acted");

  gdf_latch_a: assert property (
    rep[C_GSF] |=> gdf_lat_r ##1 gate_hiz && fault_report_n_oe)
    else $error("stuck gate fault not latched");

  gdf_off_a: assert property (
    !gf_en && !gdf_lat_r |=> !gdf_lat_r)
    else $error("disabled gate fault latched");

  tw_rep_a: assert property (
    cnd == (NCOND'(1) << C_TWN) && twr |=> fault_report_n_oe)
    else $error("thermal warning not reported");

  tw_quiet_a: assert property (
    cnd == (NCOND'(1) << C_TWN) && !twr && oc_st_r == OC_IDLE && !gdf_lat_r
    |=> !fault_report_n_oe && !gate_hiz)
    else $error("unreported thermal warning acted");

  tsd_a: assert property (
    cnd[C_TSD] |=> gate_hiz && fault_report_n_oe && (logic_disable == $past(cnd[C_SUV])))
    else $error("thermal shutdown not acted on");

  stat_a: assert property (
    cnd[C_SUV] |=> fstat_r[0] && fstat_r[1+C_SUV])
    else $error("status bits not latched");

  pin_or_a: assert property (
    fault_report_n_oe == $past(fault_any) && !fault_report_n_o)
    else $error("fault pin does not follow fault set");

  retry_c: cover property (oc_st_r == OC_RETRY ##1 oc_st_r == OC_IDLE);
  latch_c: cover property (oc_st_r == OC_LATCHED ##1 oc_st_r == OC_IDLE);
  gdf_c:   cover property (gdf_lat_r ##1 !gdf_lat_r);
  irq_c:   cover property (irq);

endmodule
`default_nettype wire

// File: verification/gdfm_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Motor controller side of the fault pin
module gdfm_ctrl_model (
  input  wire logic fault_report_n_o,
  input  wire logic fault_report_n_oe,
  output var logic  pin_level
);
  // The pin is open drain with a board pull-up, so a released pin reads high.
  always_comb begin
    pin_level = fault_report_n_oe ? fault_report_n_o : 1'b1;
  end
endmodule
`default_nettype wire

// File: verification/gdfm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gdfm_top_tb;
  import gdfm_pkg::*;
  // A short retry keeps the run brief; every wait below assumes this value.
  localparam int RETRY_SMALL = 16;

  typedef struct packed {
    logic [7:0] ctrl;
    logic       strap;
    int         idx;
    logic       oe_on;
    logic       hiz_on;
    logic       ld_on;
    logic       oe_off;
    logic       hiz_off;
    logic [7:0] fstat;
  } gdfm_case_t;

  logic             mclk = 1'b0;
  logic             rst_b = 1'b0;
  logic [7:0]       addr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [NCOND-1:0] cond = '0;
  logic             en_pulse = 1'b0;
  logic             strap = 1'b0;
  logic [31:0]      rdata;
  logic             pin, pin_o, oe, gate_hiz, logic_disable, irq;
  gdfm_case_t       cases [0:16];
  int               failures = 0;
  int               checks = 0;

  always #12.5 mclk = ~mclk;

  gdfm_top #(.RETRY_CYC(RETRY_SMALL)) gdfm_top_inst (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .supply_undervoltage(cond[C_SUV]), .pump_undervoltage(cond[C_PUV]),
    .drain_source_overcurrent(cond[C_DSOC]), .sense_resistor_overcurrent(cond[C_SNOC]),
    .gate_stuck_fault(cond[C_GSF]), .thermal_warning(cond[C_TWN]), .thermal_shutdown(cond[C_TSD]),
    .enable_reset_pulse(en_pulse), .hw_iface_strap(strap), .fault_report_n_i(pin),
    .fault_report_n_o(pin_o), .fault_report_n_oe(oe), .gate_hiz(gate_hiz),
    .logic_disable(logic_disable), .irq(irq)
  );

  gdfm_ctrl_model gdfm_ctrl_model_inst (
    .fault_report_n_o(pin_o), .fault_report_n_oe(oe), .pin_level(pin)
  );

  // ==========================================================================
  // Bus and compare helpers
  task automatic compare(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Returns just after the last edge, so outputs launched there have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m = 32'hffffffff);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 compare(name, rdata & m, exp);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // One fault: raise, check the response, drop, check recovery, then clear
  task automatic run_case(input int k);
    gdfm_case_t c;
    int         hold;
    logic       retry_on;
    c = cases[k];
    // Retry is the only overcurrent response that floats the gates and lets go by itself.
    retry_on = c.hiz_on && !c.hiz_off && (c.idx == C_DSOC || c.idx == C_SNOC);
    // Overcurrent must survive the deglitch window before anything happens.
    hold = (c.idx == C_DSOC || c.idx == C_SNOC) ? 170 : 10;
    wr_reg(A_CTRL, {24'h0, c.ctrl});
    @(posedge mclk);
    strap <= c.strap;
    cond[c.idx] <= 1'b1;
    cyc(hold);
    compare("gate_hiz on", {31'h0, gate_hiz}, {31'h0, c.hiz_on});
    compare("pin drive on", {31'h0, oe}, {31'h0, c.oe_on});
    compare("logic off", {31'h0, logic_disable}, {31'h0, c.ld_on});
    rd_chk("live", A_LIVE, {20'h0, retry_on, c.strap, c.ld_on, c.hiz_on, ~c.oe_on, 7'(1 << c.idx)});
    @(posedge mclk);
    cond[c.idx] <= 1'b0;
    cyc(40);
    compare("gate_hiz after", {31'h0, gate_hiz}, {31'h0, c.hiz_off});
    compare("pin drive after", {31'h0, oe}, {31'h0, c.oe_off});
    rd_chk("fstat held", A_FSTAT, {24'h0, c.fstat});
    if (k % 2 == 0) begin
      wr_reg(A_CTRL, {24'h0, c.ctrl | 8'h40});
    end else begin
      @(posedge mclk);
      en_pulse <= 1'b1;
      cyc(3);
      @(posedge mclk);
      en_pulse <= 1'b0;
    end
    cyc(8);
    compare("gate_hiz clr", {31'h0, gate_hiz}, 32'h0);
    compare("pin drive clr", {31'h0, oe}, 32'h0);
    rd_chk("fstat clr", A_FSTAT, 32'h0);
    rd_chk("ctrl", A_CTRL, {24'h0, c.ctrl});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    cases[0]  = '{8'h00, 1'b0, C_SUV,  1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h03};
    cases[1]  = '{8'h00, 1'b0, C_PUV,  1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h05};
    cases[2]  = '{8'h04, 1'b0, C_PUV,  1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    cases[3]  = '{8'h00, 1'b0, C_DSOC, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h09};
    cases[4]  = '{8'h01, 1'b0, C_DSOC, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
    cases[5]  = '{8'h02, 1'b0, C_DSOC, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h09};
    cases[6]  = '{8'h03, 1'b0, C_DSOC, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    cases[7]  = '{8'h00, 1'b0, C_SNOC, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h11};
    cases[8]  = '{8'h08, 1'b0, C_SNOC, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    cases[9]  = '{8'h0a, 1'b0, C_SNOC, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    cases[10] = '{8'h00, 1'b0, C_GSF,  1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h21};
    cases[11] = '{8'h10, 1'b0, C_GSF,  1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    cases[12] = '{8'h00, 1'b0, C_TWN,  1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    cases[13] = '{8'h20, 1'b0, C_TWN,  1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h41};
    cases[14] = '{8'h00, 1'b0, C_TSD,  1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h81};
    cases[15] = '{8'h08, 1'b1, C_SNOC, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
    cases[16] = '{8'h00, 1'b1, C_DSOC, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    cyc(2);
    compare("pin drive rst", {31'h0, oe}, 32'h0);
    rd_chk("ctrl rst", A_CTRL, {26'h0, CTRL_RST});
    rd_chk("fstat rst", A_FSTAT, {24'h0, FSTAT_RST});
    rd_chk("imask rst", A_IMASK, {25'h0, IRQ_RST});
    wr_reg(8'h14, 32'hffffffff);
    rd_chk("unmapped", 8'h14, 32'h0);
    for (int k = 0; k < 17; k++) begin
      run_case(k);
    end
    @(posedge mclk);
    strap <= 1'b0;
    // Interrupt: sticky status, mask, level output, write one to clear.
    wr_reg(A_ISTAT, 32'h7f);
    rd_chk("istat clr", A_ISTAT, 32'h0);
    wr_reg(A_IMASK, 32'h40);
    rd_chk("imask", A_IMASK, 32'h40);
    @(posedge mclk);
    cond[C_TSD] <= 1'b1;
    cyc(9);
    @(posedge mclk);
    cond[C_TSD] <= 1'b0;
    cyc(10);
    compare("irq set", {31'h0, irq}, 32'h1);
    rd_chk("istat set", A_ISTAT, 32'h40);
    wr_reg(A_IMASK, 32'h0);
    cyc(2);
    compare("irq masked", {31'h0, irq}, 32'h0);
    wr_reg(A_IMASK, 32'h40);
    cyc(2);
    compare("irq unmasked", {31'h0, irq}, 32'h1);
    wr_reg(A_ISTAT, 32'h40);
    cyc(2);
    compare("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk("istat w1c", A_ISTAT, 32'h0);
    // A clear issued into a live latched overcurrent must not release the gates.
    @(posedge mclk);
    cond[C_DSOC] <= 1'b1;
    cyc(170);
    wr_reg(A_CTRL, 32'h40);
    cyc(4);
    compare("gate_hiz live clr", {31'h0, gate_hiz}, 32'h1);
    rd_chk("fstat live clr", A_FSTAT, 32'h9);
    @(posedge mclk);
    cond[C_DSOC] <= 1'b0;
    cyc(8);
    wr_reg(A_CTRL, 32'h40);
    cyc(4);
    compare("gate_hiz late clr", {31'h0, gate_hiz}, 32'h0);
    compare("pin drive late clr", {31'h0, oe}, 32'h0);
    rd_chk("fstat late clr", A_FSTAT, 32'h0);
    summarize();
  end

  // The full sequence needs about 3000 cycles; more than six times that means a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
